// File: core/fpc_pkg.sv
// Purpose: Constants for the parallel configuration host controller
// Assumes: 250 MHz system clock, 4 ns period
// Notes: Times kept in printed units, cycle counts derived
package fpc_pkg;
   // ******************************************
   // Timing
   // ******************************************
   localparam int CLK_MHZ = 250;
   localparam int T_REQ_LOW_US = 2;
   localparam int T_STAT_TO_CLK_US = 2;
   localparam int T_REQ_TO_CLK_US = 1506;
   localparam int T_INIT_MAX_US = 437;
   localparam int T_INIT_USR_PERIODS = 8576;
   localparam int REQ_LOW_CYC = T_REQ_LOW_US * CLK_MHZ;
   localparam int STAT_TO_CLK_CYC = T_STAT_TO_CLK_US * CLK_MHZ;
   localparam int REQ_TO_CLK_CYC = T_REQ_TO_CLK_US * CLK_MHZ;
   localparam int INIT_WAIT_CYC = T_INIT_MAX_US * CLK_MHZ;
   localparam int EXTRA_FALL_EDGES = 2;
   // Half period of the configuration clock: 4 cycles gives 31.25 MHz
   localparam int HALF_CYC_DEF = 4;
   // ******************************************
   // Register map
   // ******************************************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_DATA = 4'h2;
   localparam logic [3:0] REG_COUNT = 4'h3;
   localparam logic [3:0] REG_RATIO = 4'h4;
   localparam int CTRL_START = 0;
   localparam int CTRL_WATCH = 1;
   localparam int CTRL_ABORT = 2;
   localparam int CTRL_WIDTH_LO = 4;
   localparam int CTRL_USRCLK = 6;
   localparam logic [1:0] WIDTH_X8 = 2'h0;
   localparam logic [1:0] WIDTH_X16 = 2'h1;
   localparam logic [1:0] WIDTH_X32 = 2'h2;
   localparam logic [7:0] RATIO_RST = 8'h01;
   // ******************************************
   // States
   // ******************************************
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_REQ_LOW = 4'b0001,
      ST_WAIT_STAT = 4'b0010,
      ST_WAIT_SETUP = 4'b0011,
      ST_WAIT_WORD = 4'b0100,
      ST_CLK_LOW = 4'b0101,
      ST_CLK_HIGH = 4'b0110,
      ST_TAIL = 4'b0111,
      ST_INIT = 4'b1000,
      ST_DONE = 4'b1001,
      ST_FAIL = 4'b1010
   } fpc_state_e;
endpackage

// File: core/fpc_host.sv
// Purpose: Host that loads an image through the fast passive parallel port
// Assumes: Pins from the device are asynchronous, synchronised here
// Notes: Software pushes each word through a data register; clock pauses low
//
// Contract
// - Idle in user mode has request high; reconfiguration starts by driving request low.
// - After completion the configuration clock is parked at a defined level.
// - Bus width follows mode: 8 bits, 16 bits, or all 32 bits.
// - Host sends the whole image; complete rises only after every word.
// - After complete rises the host gives two more falling clock edges.
// - Host holds request low for at least 2 us.
// - Host waits 2 us after status rises, or 1,506 us unwatched.
// - Device samples data on the clock rising edge; host sets data first.
// - Clock at most 125 MHz for 8/16-bit, 100 MHz for 32-bit.
// - With ratio above one the host may pause clock low, data valid first.
// - Ratio r sets how many clock cycles each data word gets.
// - One word per clock applies only without decompression and security.
`timescale 1ns/1ns
module fpc_host #(
   parameter int REQ_TO_CLK_CYC = fpc_pkg::REQ_TO_CLK_CYC,
   parameter int INIT_WAIT_CYC = fpc_pkg::INIT_WAIT_CYC,
   parameter int HALF_CYC = fpc_pkg::HALF_CYC_DEF,
   parameter int TAIL_WORDS = 64
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Device pins
   output logic config_request_n,
   output logic config_clock,
   output logic [31:0] config_data,
   output logic config_data_oe_n,
   input wire logic status_n_in,
   input wire logic config_complete,
   input wire logic init_done_in
);
   // ******************************************
   // Synchronisers
   // ******************************************
   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1_r <= 3'h0;
         sync2_r <= 3'h0;
      end
      else
      begin
         sync1_r <= {init_done_in, config_complete, status_n_in};
         sync2_r <= sync1_r;
      end
   end
   wire status_hi = sync2_r[0];
   wire complete_hi = sync2_r[1];
   wire init_hi = sync2_r[2];

   // ******************************************
   // Registers
   // ******************************************
   logic watch_r;
   logic usrclk_r;
   logic [1:0] width_r;
   logic [7:0] ratio_r;
   logic [31:0] word_r;
   logic word_full_r;
   logic [31:0] count_r;
   logic [31:0] sent_r;
   logic fail_r;
   logic [31:0] reg_rdata_r;
   fpc_pkg::fpc_state_e state_r;
   fpc_pkg::fpc_state_e state_nxt;
   logic [31:0] tmr_r;
   logic [31:0] tmr_nxt;
   logic [7:0] rep_r;
   logic [7:0] rep_nxt;
   logic [1:0] tail_r;
   logic [1:0] tail_nxt;

   wire wr_ctrl = reg_wr && (reg_addr == fpc_pkg::REG_CTRL);
   wire wr_data = reg_wr && (reg_addr == fpc_pkg::REG_DATA);
   wire wr_count = reg_wr && (reg_addr == fpc_pkg::REG_COUNT);
   wire wr_ratio = reg_wr && (reg_addr == fpc_pkg::REG_RATIO);
   wire start_req = wr_ctrl && reg_wdata[fpc_pkg::CTRL_START];
   wire abort_req = wr_ctrl && reg_wdata[fpc_pkg::CTRL_ABORT];
   wire busy = (state_r != fpc_pkg::ST_IDLE) && (state_r != fpc_pkg::ST_DONE)
      && (state_r != fpc_pkg::ST_FAIL);
   wire all_sent = (sent_r == count_r);
   wire word_take = (state_r == fpc_pkg::ST_WAIT_WORD) && word_full_r && !all_sent;
   wire last_rep = (rep_r + 8'h01 >= ratio_r);

   // Mask unused lanes so the device sees clean upper bits
   wire [31:0] lane_mask = (width_r == fpc_pkg::WIDTH_X8) ? 32'h000000ff :
      (width_r == fpc_pkg::WIDTH_X16) ? 32'h0000ffff : 32'hffffffff;
   wire [31:0] status_word = {22'h0, fail_r, init_hi, complete_hi, status_hi,
      word_full_r, busy, state_r};

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         watch_r <= 1'b1;
         usrclk_r <= 1'b0;
         width_r <= fpc_pkg::WIDTH_X8;
         ratio_r <= fpc_pkg::RATIO_RST;
         count_r <= 32'h0;
      end
      else
      begin
         if (wr_ctrl && !busy)
         begin
            watch_r <= reg_wdata[fpc_pkg::CTRL_WATCH];
            usrclk_r <= reg_wdata[fpc_pkg::CTRL_USRCLK];
            width_r <= reg_wdata[fpc_pkg::CTRL_WIDTH_LO +: 2];
         end
         if (wr_ratio && !busy)
            ratio_r <= (reg_wdata[7:0] == 8'h00) ? fpc_pkg::RATIO_RST : reg_wdata[7:0];
         if (wr_count && !busy)
            count_r <= reg_wdata;
      end
   end

   // Word holding register; software polls the full flag before writing
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         word_r <= 32'h0;
         word_full_r <= 1'b0;
      end
      else if (word_take)
         word_full_r <= 1'b0;
      else if (wr_data && !word_full_r)
      begin
         word_r <= reg_wdata & lane_mask;
         word_full_r <= 1'b1;
      end
   end

   wire [31:0] rd_mux = (reg_addr == fpc_pkg::REG_CTRL) ? {25'h0, usrclk_r, width_r,
         1'b0, 1'b0, watch_r, 1'b0} :
      (reg_addr == fpc_pkg::REG_STATUS) ? status_word :
      (reg_addr == fpc_pkg::REG_COUNT) ? count_r :
      (reg_addr == fpc_pkg::REG_RATIO) ? {24'h0, ratio_r} :
      (reg_addr == fpc_pkg::REG_DATA) ? sent_r : 32'h0;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata_r <= 32'h0;
      else if (reg_rd)
         reg_rdata_r <= rd_mux;
      else
         reg_rdata_r <= 32'h0;
   end
   assign reg_rdata = reg_rdata_r;

   // ******************************************
   // Sequencer
   // ******************************************
   localparam int INIT_USR_CYC = (fpc_pkg::T_INIT_USR_PERIODS + 4) * 2 * HALF_CYC;
   localparam int TAIL_CYC = TAIL_WORDS * 2 * HALF_CYC;
   wire [31:0] half_m1 = 32'(HALF_CYC - 1);

   always_comb
   begin
      state_nxt = state_r;
      tmr_nxt = tmr_r + 32'h1;
      rep_nxt = rep_r;
      tail_nxt = tail_r;
      case (state_r)
         fpc_pkg::ST_IDLE, fpc_pkg::ST_DONE, fpc_pkg::ST_FAIL:
         begin
            tmr_nxt = 32'h0;
            tail_nxt = 2'h0;
            if (start_req)
               state_nxt = fpc_pkg::ST_REQ_LOW;
         end
         fpc_pkg::ST_REQ_LOW:
            if (tmr_r >= 32'(fpc_pkg::REQ_LOW_CYC - 1))
            begin
               state_nxt = fpc_pkg::ST_WAIT_STAT;
               tmr_nxt = 32'h0;
            end
         fpc_pkg::ST_WAIT_STAT:
            if (!watch_r)
            begin
               if (tmr_r >= 32'(REQ_TO_CLK_CYC - 1))
               begin
                  state_nxt = fpc_pkg::ST_WAIT_WORD;
                  tmr_nxt = 32'h0;
               end
            end
            else if (status_hi)
            begin
               state_nxt = fpc_pkg::ST_WAIT_SETUP;
               tmr_nxt = 32'h0;
            end
         fpc_pkg::ST_WAIT_SETUP:
            if (!status_hi)
               tmr_nxt = 32'h0;
            else if (tmr_r >= 32'(fpc_pkg::STAT_TO_CLK_CYC - 1))
            begin
               state_nxt = fpc_pkg::ST_WAIT_WORD;
               tmr_nxt = 32'h0;
            end
         fpc_pkg::ST_WAIT_WORD:
         begin
            tmr_nxt = 32'h0;
            rep_nxt = 8'h0;
            // Clock paused low while no word waits
            if (all_sent)
               state_nxt = fpc_pkg::ST_TAIL;
            else if (word_full_r)
               state_nxt = fpc_pkg::ST_CLK_LOW;
         end
         fpc_pkg::ST_CLK_LOW:
            if (tmr_r >= half_m1)
            begin
               state_nxt = fpc_pkg::ST_CLK_HIGH;
               tmr_nxt = 32'h0;
            end
         fpc_pkg::ST_CLK_HIGH:
            if (tmr_r >= half_m1)
            begin
               tmr_nxt = 32'h0;
               // Fall ending the last word counts only if done is already seen
               if (complete_hi && (tail_r != 2'(fpc_pkg::EXTRA_FALL_EDGES)))
                  tail_nxt = tail_r + 2'h1;
               if (last_rep)
                  state_nxt = fpc_pkg::ST_WAIT_WORD;
               else
               begin
                  rep_nxt = rep_r + 8'h01;
                  state_nxt = fpc_pkg::ST_CLK_LOW;
               end
            end
         fpc_pkg::ST_TAIL:
         begin
            // Free-run clock after the image; count falls once complete seen
            if (tmr_r >= 32'(2 * HALF_CYC - 1))
            begin
               tmr_nxt = 32'h0;
               if (complete_hi)
                  tail_nxt = tail_r + 2'h1;
               rep_nxt = rep_r + 8'h01;
            end
            if (tail_r == 2'(fpc_pkg::EXTRA_FALL_EDGES))
            begin
               state_nxt = fpc_pkg::ST_INIT;
               tmr_nxt = 32'h0;
            end
            else if (!complete_hi && 32'(rep_r) * 32'(2 * HALF_CYC) >= 32'(TAIL_CYC))
               state_nxt = fpc_pkg::ST_FAIL;
         end
         fpc_pkg::ST_INIT:
            if (tmr_r >= (usrclk_r ? 32'(INIT_USR_CYC) : 32'(INIT_WAIT_CYC)))
               state_nxt = fpc_pkg::ST_DONE;
         default:
            state_nxt = fpc_pkg::ST_IDLE;
      endcase
      if (abort_req)
         state_nxt = fpc_pkg::ST_IDLE;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= fpc_pkg::ST_IDLE;
         tmr_r <= 32'h0;
         rep_r <= 8'h0;
         tail_r <= 2'h0;
      end
      else
      begin
         state_r <= state_nxt;
         tmr_r <= tmr_nxt;
         rep_r <= rep_nxt;
         tail_r <= tail_nxt;
      end
   end

   // Counts words sent and remembers failures
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sent_r <= 32'h0;
         fail_r <= 1'b0;
      end
      else
      begin
         if (state_r == fpc_pkg::ST_REQ_LOW)
            sent_r <= 32'h0;
         else if (word_take)
            sent_r <= sent_r + 32'h1;
         if (state_nxt == fpc_pkg::ST_FAIL)
            fail_r <= 1'b1;
         else if (state_r == fpc_pkg::ST_REQ_LOW)
            fail_r <= 1'b0;
      end
   end

   // ******************************************
   // Pin drivers
   // ******************************************
   wire clk_hi_nxt = (state_nxt == fpc_pkg::ST_CLK_HIGH) ||
      ((state_nxt == fpc_pkg::ST_TAIL) && (tmr_nxt >= 32'(HALF_CYC)));
   wire drive_nxt = (state_nxt == fpc_pkg::ST_WAIT_WORD) ||
      (state_nxt == fpc_pkg::ST_CLK_LOW) || (state_nxt == fpc_pkg::ST_CLK_HIGH) ||
      (state_nxt == fpc_pkg::ST_TAIL);
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         config_request_n <= 1'b1;
         config_clock <= 1'b0;
         config_data <= 32'h0;
         config_data_oe_n <= 1'b1;
      end
      else
      begin
         config_request_n <= (state_nxt != fpc_pkg::ST_REQ_LOW);
         // Parked low whenever not toggling, never floated
         config_clock <= clk_hi_nxt;
         if (word_take)
            config_data <= word_r;
         // Released after load so the device may reuse the pins
         config_data_oe_n <= !drive_nxt;
      end
   end
endmodule // fpc_host

// File: sim/fpc_host_properties.sv
// Purpose: Port properties of the configuration host
// Assumes: One clock domain, async active-low reset
// Notes: Counters stand in for long spans
`timescale 1ns/1ns
module fpc_host_properties #(
   parameter int HALF_CYC = 4,
   parameter int REQ_TO_CLK_CYC = 200
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // Device pins
   input wire logic config_request_n,
   input wire logic config_clock,
   input wire logic [31:0] config_data,
   input wire logic config_data_oe_n,
   input wire logic status_n_in,
   input wire logic config_complete,
   input wire logic init_done_in
);
   // ****
   // Helper counters
   // ****
   logic [19:0] low_cnt_r, hi_cnt_r, lo_cnt_r, since_req_r, since_stat_r;
   logic [3:0] falls_r;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         low_cnt_r <= '0;
         hi_cnt_r <= '0;
         lo_cnt_r <= '0;
         since_req_r <= '0;
         since_stat_r <= '0;
         falls_r <= '0;
      end
      else
      begin
         low_cnt_r <= config_request_n ? '0 : low_cnt_r + 20'h1;
         hi_cnt_r <= config_clock ? hi_cnt_r + 20'h1 : '0;
         lo_cnt_r <= config_clock ? '0 : lo_cnt_r + 20'h1;
         since_req_r <= config_request_n ? since_req_r + 20'h1 : '0;
         since_stat_r <= status_n_in ? since_stat_r + 20'h1 : '0;
         // Saturates so a runaway tail cannot wrap back into range
         falls_r <= !config_request_n ? '0 :
            falls_r + {3'h0, config_complete && $fell(config_clock) && falls_r != 4'hf};
      end
   end
   // ****
   // Properties
   // ****
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   AST_REQ_LOW_WIDTH: assert property (
      $rose(config_request_n) |-> low_cnt_r >= fpc_pkg::REQ_LOW_CYC)
      else $error("request low pulse too short");
   AST_CLK_HIGH_TIME: assert property (
      $fell(config_clock) |-> hi_cnt_r == HALF_CYC)
      else $error("clock high time wrong");
   AST_CLK_LOW_TIME: assert property (
      $rose(config_clock) |-> lo_cnt_r >= HALF_CYC)
      else $error("clock low time too short");
   AST_FIRST_RISE: assert property (
      $rose(config_clock) |->
      (since_stat_r >= fpc_pkg::STAT_TO_CLK_CYC || since_req_r >= REQ_TO_CLK_CYC))
      else $error("clock rose too early");
   AST_PARK_IN_REQ: assert property (
      !config_request_n |-> !config_clock && config_data_oe_n)
      else $error("pins active while request low");
   AST_TWO_FALLS: assert property (
      $rose(config_complete) |-> ##[1:64] $fell(config_clock) ##[1:64] $fell(config_clock))
      else $error("tail falling edges missing");
   AST_FALL_LIMIT: assert property (
      falls_r <= 4'h2)
      else $error("clock kept running after completion");
   AST_DATA_STABLE_HI: assert property (
      config_clock |-> $stable(config_data) && !config_data_oe_n)
      else $error("data moved while clock high");
   AST_RDATA_ZERO: assert property (
      !$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
endmodule // fpc_host_properties
bind fpc_host fpc_host_properties #(.HALF_CYC(HALF_CYC), .REQ_TO_CLK_CYC(REQ_TO_CLK_CYC)) u_props (
   .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .config_request_n(config_request_n),
   .config_clock(config_clock), .config_data(config_data), .config_data_oe_n(config_data_oe_n),
   .status_n_in(status_n_in), .config_complete(config_complete), .init_done_in(init_done_in));

// File: sim/fpc_dev_model.sv
// Purpose: Behavioural model of the configured device
// Assumes: Spans shortened to nanoseconds
// Notes: Records every sampled word for the bench
`timescale 1ns/1ns
module fpc_dev_model #(
   parameter int POR_NS = 400,
   parameter int STAT_NS = 600,
   parameter int INIT_NS = 200
) (
   // Pins from the host
   input wire logic config_request_n,
   input wire logic config_clock,
   input wire logic [31:0] config_data,
   // Pins to the host
   output logic status_oe_n,
   output logic config_complete,
   output logic init_done,
   // Image shape set by the bench
   input var int need,
   input var int ratio,
   input wire logic bad
);
   logic [31:0] cap [0:255];
   int rises, falls;
   realtime t_low, t_req, t_stat, t_first, t_cd;
   initial
   begin
      status_oe_n = 1'b0;
      config_complete = 1'b0;
      init_done = 1'b0;
      rises = 0;
      falls = 0;
      #(POR_NS);
      // A request already pending keeps status low
      if (config_request_n)
         status_oe_n = 1'b1;
   end
   always @(negedge config_request_n)
   begin
      t_low = $realtime;
      rises = 0;
      falls = 0;
      #100 config_complete = 1'b0;
      status_oe_n = 1'b0;
      init_done = 1'b0;
   end
   always @(posedge config_request_n)
   begin
      t_req = $realtime;
      #(STAT_NS);
      if (config_request_n)
      begin
         status_oe_n = 1'b1;
         t_stat = $realtime;
      end
   end
   // Rising edges ignored once complete, pins handed back
   always @(posedge config_clock)
   begin
      if (!config_complete)
      begin
         if (rises == 0)
            t_first = $realtime;
         cap[rises[7:0]] = config_data;
         rises = rises + 1;
         if (rises == need * ratio && !bad)
         begin
            config_complete <= 1'b1;
            t_cd = $realtime;
         end
      end
   end
   always @(negedge config_clock)
   begin
      if (config_complete)
      begin
         falls = falls + 1;
         if (falls == 2)
            #(INIT_NS) init_done = 1'b1;
      end
   end
endmodule // fpc_dev_model

// File: sim/fast_parallel_config_slave_test.sv
// Purpose: Self-checking bench for the configuration host
// Assumes: Device model on the pins, short timing parameters
// Notes: Word polling between writes forces clock pauses
`timescale 1ns/1ns
module fast_parallel_config_slave_test;
   logic clk, rst_n, reg_wr, reg_rd, dev_bad, status_oe_n, status_line, config_complete;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, config_data, v;
   logic config_request_n, config_clock, config_data_oe_n, init_done, usr_init;
   int dev_need, dev_ratio, bad_count, comparisons;
   // Open-drain status line with pull-up
   assign status_line = status_oe_n ? 1'b1 : 1'b0;
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   fpc_host #(.REQ_TO_CLK_CYC(200), .INIT_WAIT_CYC(100), .HALF_CYC(4), .TAIL_WORDS(64)) dut (
      .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .config_request_n(config_request_n),
      .config_clock(config_clock), .config_data(config_data), .config_data_oe_n(config_data_oe_n),
      .status_n_in(status_line), .config_complete(config_complete), .init_done_in(init_done));
   fpc_dev_model dev (.config_request_n(config_request_n), .config_clock(config_clock),
      .config_data(config_data), .status_oe_n(status_oe_n), .config_complete(config_complete),
      .init_done(init_done), .need(dev_need), .ratio(dev_ratio), .bad(dev_bad));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
   endtask
   function automatic logic [31:0] img_word(input int i);
      return 32'hc3a5_5a3c + 32'(i) * 32'h1111_1111;
   endfunction
   task automatic wait_state(input fpc_pkg::fpc_state_e s);
      logic [31:0] q;
      q = '0;
      for (int n = 0; n < 50000 && q[3:0] !== s; n++)
         rd(fpc_pkg::REG_STATUS, q);
      check({28'h0, q[3:0]}, {28'h0, s});
   endtask
   task automatic run_image(input logic [1:0] w, input int r, input logic watch, input int nw,
      input logic bad);
      logic [31:0] m, q, ctrl;
      m = (w == fpc_pkg::WIDTH_X8) ? 32'h0000_00ff :
         ((w == fpc_pkg::WIDTH_X16) ? 32'h0000_ffff : 32'hffff_ffff);
      ctrl = (32'(w) << fpc_pkg::CTRL_WIDTH_LO) | (32'(watch) << fpc_pkg::CTRL_WATCH)
         | (32'(usr_init) << fpc_pkg::CTRL_USRCLK);
      dev_need <= nw;
      dev_ratio <= r;
      dev_bad <= bad;
      wr(fpc_pkg::REG_COUNT, 32'(nw));
      wr(fpc_pkg::REG_RATIO, 32'(r));
      wr(fpc_pkg::REG_CTRL, ctrl);
      wr(fpc_pkg::REG_CTRL, ctrl | 32'h1);
      for (int i = 0; i < nw; i++)
      begin
         q = 32'h20;
         for (int n = 0; n < 5000 && q[5] !== 1'b0; n++)
            rd(fpc_pkg::REG_STATUS, q);
         wr(fpc_pkg::REG_DATA, img_word(i));
      end
      wait_state(bad ? fpc_pkg::ST_FAIL : fpc_pkg::ST_DONE);
      rd(fpc_pkg::REG_STATUS, q);
      check({29'h0, q[9], q[8], q[7]}, bad ? 32'h4 : 32'h3);
      if (!bad)
      begin
         for (int i = 0; i < nw * r; i++)
            check(dev.cap[i], img_word(i / r) & m);
         check(32'(dev.rises), 32'(nw * r));
         check(32'(dev.falls), 32'h2);
         check({30'h0, config_clock, config_data_oe_n}, 32'h1);
         check({31'h0, watch ? (dev.t_first - dev.t_stat >= 2000.0) :
            (dev.t_first - dev.t_req >= 800.0)}, 32'h1);
         check({31'h0, dev.t_req - dev.t_low >= 2000.0}, 32'h1);
         rd(fpc_pkg::REG_DATA, q);
         check(q, 32'(nw));
         // User clock proxied by the 32 ns configuration clock
         if (usr_init)
            check({31'h0, $realtime - dev.t_cd >= (fpc_pkg::T_INIT_USR_PERIODS + 4) * 32.0},
               32'h1);
      end
      $display("test width %0d ratio %0d fault %0d done", w, r, bad);
   endtask
   initial
   begin
      #400000;
      bad_count++;
      $display("watchdog expired");
      give_verdict();
   end
   initial
   begin
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = '0;
      dev_bad = 1'b0;
      usr_init = 1'b0;
      dev_need = 1;
      dev_ratio = 1;
      bad_count = 0;
      comparisons = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check({29'h0, config_request_n, config_clock, config_data_oe_n}, 32'h5);
      rd(fpc_pkg::REG_RATIO, v);
      check(v, {24'h0, fpc_pkg::RATIO_RST});
      rd(4'hf, v);
      check(v, 32'h0);
      $display("test reset done");
      run_image(fpc_pkg::WIDTH_X8, 1, 1'b1, 4, 1'b0);
      run_image(fpc_pkg::WIDTH_X16, 2, 1'b1, 3, 1'b0);
      run_image(fpc_pkg::WIDTH_X32, 3, 1'b0, 3, 1'b0);
      run_image(fpc_pkg::WIDTH_X8, 1, 1'b1, 2, 1'b1);
      run_image(fpc_pkg::WIDTH_X16, 1, 1'b0, 2, 1'b0);
      usr_init = 1'b1;
      run_image(fpc_pkg::WIDTH_X8, 1, 1'b1, 2, 1'b0);
      give_verdict();
   end
endmodule // fast_parallel_config_slave_test
